// ---- include/host_fifo_pkg.sv ----
package host_fifo_pkg;
  localparam logic [7:0] INTERRUPT_MODE_CONTROL_OFS = 8'h90;
  localparam logic [7:0] IRQ_VECTOR_WRITE_PORT_OFS  = 8'h98;
  localparam logic [7:0] IRQ_VECTOR_READ_PORT_OFS   = 8'h9C;
  localparam logic [7:0] FIFO_FLUSH_CONTROL_OFS     = 8'h80;
  localparam logic [7:0] FIFO_DATA_READ_OFS         = 8'h02;
  localparam logic [7:0] FIFO_COUNTER_STATUS_OFS    = 8'h82;
  localparam logic [7:0] FIFO_LEVEL_DMA_CONTROL_OFS = 8'h84;
  localparam logic [7:0] FIFO_WRITE_DATA_OFS        = 8'h00;
  localparam int          AUTO_CLEAR_BIT    = 15;
  localparam int          VECTORED_BIT      = 14;
  localparam int          STATUS_N_BIT      = 7;
  localparam int          FLUSH_BIT         = 0;
  localparam int          ALLOW_BIT         = 0;
  localparam int          ENABLES_LSB       = 1;
  localparam int          FLAGS_LSB         = 5;
  localparam int          FILL_LSB          = 8;
  localparam int          WPTR_LSB          = 4;
  localparam int          PRIO_LSB          = 8;
  localparam logic [7:0]  VECTOR_RESET      = 8'h0F;
  localparam logic [2:0]  PRIO_RESET        = 3'h0;
  localparam logic [4:0]  FIFO_DEPTH        = 5'h10;
endpackage

// ---- core/host_fifo_dma_and_irq_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_fifo_dma_and_irq_ctrl #(
  parameter int DATA_W = 16
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [15:0]       reg_wdata_i,
  output logic      [15:0]       reg_rdata_o,
  input  wire logic              transfer_ack_i,
  input  wire logic              transfer_done_n_i,
  input  wire logic              drain_i,
  output logic      [DATA_W-1:0] drain_data_o,
  output logic                   drain_valid_o,
  input  wire logic              irq_ack_n_i,
  input  wire logic [3:1]        host_addr_i,
  output logic      [7:0]        vector_data_o,
  output logic                   vector_oe_n_o,
  output logic                   irq_n_o,
  output logic                   irq_oe_n_o,
  output logic                   fifo_level_pin_o,
  output logic                   transfer_request_n_o
);
  typedef struct packed {
    logic [1:0] done_sync;
    logic [1:0] ack_sync;
    logic       ack_prev;
    logic       dma_on;
    logic       allow_bit;
    logic [3:0] quarter_flag_enables;
    logic       fifo_flush;
    logic       auto_irq_clear;
    logic       vectored_irq_on;
    logic       status_n;
    logic [2:0] priority_code;
    logic [7:0] irq_vector_value;
    logic [4:0] fill_level_count;
    logic [3:0] fifo_write_pointer;
    logic [3:0] fifo_read_pointer;
    logic [15:0] rdata;
    logic [DATA_W-1:0] drain_data;
    logic       drain_valid;
    logic [7:0] vector_data;
    logic       vector_drive;
    logic       level_pin;
  } state_t;

  state_t            st;
  state_t            next_st;
  logic [DATA_W-1:0] mem [16];
  logic              wr_word;
  logic              rd_word;
  logic              full;
  logic [4:0]        empties;
  logic [3:0]        quarter_empty_flags;
  logic              ack_n_eff;
  logic              done_n_eff;

  always_comb begin
    full    = (st.fill_level_count == host_fifo_pkg::FIFO_DEPTH);
    empties = host_fifo_pkg::FIFO_DEPTH - st.fill_level_count;
    // Bit 3 is the first quarter flag, bit 0 the last.
    quarter_empty_flags = {empties >= 5'h04, empties >= 5'h08, empties >= 5'h0C, empties >= 5'h10};
    done_n_eff = st.done_sync[1];
    ack_n_eff  = st.vectored_irq_on ? st.ack_sync[1] : 1'b1;
    // The DMA write path is qualified by the request so a stray ack cannot overflow.
    wr_word = ((reg_wr_i && reg_addr_i == host_fifo_pkg::FIFO_WRITE_DATA_OFS) ||
               (transfer_ack_i && st.dma_on)) && !full && !st.fifo_flush;
    rd_word = drain_i && (st.fill_level_count != 5'h00) && !st.fifo_flush;
  end

  always_comb begin
    next_st = st;
    next_st.done_sync   = {st.done_sync[0], transfer_done_n_i};
    next_st.ack_sync    = {st.ack_sync[0], irq_ack_n_i};
    next_st.ack_prev    = ack_n_eff;
    next_st.drain_valid = 1'b0;
    if (wr_word) begin
      next_st.fifo_write_pointer = st.fifo_write_pointer + 4'h1;
    end
    if (rd_word) begin
      next_st.fifo_read_pointer = st.fifo_read_pointer + 4'h1;
      next_st.drain_data        = mem[st.fifo_read_pointer];
      next_st.drain_valid       = 1'b1;
    end
    if (wr_word && !rd_word) begin
      next_st.fill_level_count = st.fill_level_count + 5'h01;
    end else if (rd_word && !wr_word) begin
      next_st.fill_level_count = st.fill_level_count - 5'h01;
    end
    if (!done_n_eff && !full) begin
      next_st.allow_bit = 1'b0;
      next_st.dma_on    = 1'b0;
    end
    // Ack rising edge closes the acknowledge cycle; with vectored mode and auto-clear on, the status bit is released then.
    if (st.vectored_irq_on && st.auto_irq_clear && !st.ack_prev && ack_n_eff) begin
      next_st.status_n = 1'b1;
    end
    next_st.vector_drive = !ack_n_eff && (host_addr_i == st.priority_code);
    next_st.vector_data  = st.irq_vector_value;
    if (reg_wr_i) begin
      if (reg_addr_i == host_fifo_pkg::INTERRUPT_MODE_CONTROL_OFS) begin
        next_st.auto_irq_clear  = reg_wdata_i[host_fifo_pkg::AUTO_CLEAR_BIT];
        next_st.vectored_irq_on = reg_wdata_i[host_fifo_pkg::VECTORED_BIT];
        next_st.status_n        = reg_wdata_i[host_fifo_pkg::STATUS_N_BIT];
      end else if (reg_addr_i == host_fifo_pkg::IRQ_VECTOR_WRITE_PORT_OFS) begin
        next_st.priority_code    = reg_wdata_i[host_fifo_pkg::PRIO_LSB +: 3];
        next_st.irq_vector_value = reg_wdata_i[7:0];
      end else if (reg_addr_i == host_fifo_pkg::FIFO_FLUSH_CONTROL_OFS) begin
        next_st.fifo_flush = reg_wdata_i[host_fifo_pkg::FLUSH_BIT];
      end else if (reg_addr_i == host_fifo_pkg::FIFO_LEVEL_DMA_CONTROL_OFS) begin
        next_st.quarter_flag_enables = reg_wdata_i[host_fifo_pkg::ENABLES_LSB +: 4];
        next_st.allow_bit            = reg_wdata_i[host_fifo_pkg::ALLOW_BIT];
        if (!reg_wdata_i[host_fifo_pkg::ALLOW_BIT]) begin
          next_st.dma_on = 1'b0;
        end else if (!full) begin
          next_st.dma_on = 1'b1;
        end
      end
    end
    if (st.fifo_flush) begin
      next_st.fill_level_count   = 5'h00;
      next_st.fifo_write_pointer = 4'h0;
      next_st.fifo_read_pointer  = 4'h0;
    end
    next_st.level_pin = 1'b0;
    if (st.quarter_flag_enables[3]) begin
      next_st.level_pin = quarter_empty_flags[3];
    end else if (st.quarter_flag_enables[2]) begin
      next_st.level_pin = quarter_empty_flags[2];
    end else if (st.quarter_flag_enables[1]) begin
      next_st.level_pin = quarter_empty_flags[1];
    end else if (st.quarter_flag_enables[0]) begin
      next_st.level_pin = quarter_empty_flags[0];
    end
    next_st.rdata = 16'h0000;
    if (reg_rd_i) begin
      if (reg_addr_i == host_fifo_pkg::INTERRUPT_MODE_CONTROL_OFS) begin
        next_st.rdata = {st.auto_irq_clear, st.vectored_irq_on, 6'h00, st.status_n, 7'h00};
      end else if (reg_addr_i == host_fifo_pkg::IRQ_VECTOR_READ_PORT_OFS) begin
        next_st.rdata = {5'h00, st.priority_code, st.irq_vector_value};
      end else if (reg_addr_i == host_fifo_pkg::FIFO_FLUSH_CONTROL_OFS) begin
        next_st.rdata = {15'h0000, st.fifo_flush};
      end else if (reg_addr_i == host_fifo_pkg::FIFO_DATA_READ_OFS) begin
        next_st.rdata = 16'(mem[st.fifo_read_pointer]);
      end else if (reg_addr_i == host_fifo_pkg::FIFO_COUNTER_STATUS_OFS) begin
        next_st.rdata = {3'h0, st.fill_level_count, st.fifo_write_pointer, st.fifo_read_pointer};
      end else if (reg_addr_i == host_fifo_pkg::FIFO_LEVEL_DMA_CONTROL_OFS) begin
        next_st.rdata = {7'h00, quarter_empty_flags, st.quarter_flag_enables, st.allow_bit};
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st                  <= '0;
      st.done_sync        <= 2'h3;
      st.ack_sync         <= 2'h3;
      st.ack_prev         <= 1'b1;
      st.status_n         <= 1'b1;
      st.priority_code    <= host_fifo_pkg::PRIO_RESET;
      st.irq_vector_value <= host_fifo_pkg::VECTOR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Storage has no reset; flushing only discards it logically via the pointers.
  always_ff @(posedge clk_sys_i) begin
    if (wr_word) begin
      mem[st.fifo_write_pointer] <= DATA_W'(reg_wdata_i);
    end
  end

  assign reg_rdata_o          = st.rdata;
  assign drain_data_o         = st.drain_data;
  assign drain_valid_o        = st.drain_valid;
  assign vector_data_o        = st.vector_data;
  assign vector_oe_n_o        = !st.vector_drive;
  assign irq_n_o              = 1'b0;
  assign irq_oe_n_o           = st.status_n;
  assign fifo_level_pin_o     = st.level_pin;
  assign transfer_request_n_o = !(st.dma_on && !full);
endmodule
`default_nettype wire

// ---- tb/host_fifo_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_fifo_sva (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        drain_i,
  input wire logic        drain_valid_o,
  input wire logic        irq_ack_n_i,
  input wire logic        vector_oe_n_o,
  input wire logic        irq_n_o,
  input wire logic        irq_oe_n_o,
  input wire logic        fifo_level_pin_o,
  input wire logic        transfer_request_n_o
);
  wire w84 = reg_wr_i && reg_addr_i == 8'h84;
  wire w90 = reg_wr_i && reg_addr_i == 8'h90;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data not idle");
  a_irq_pin_low: assert property (irq_n_o == 1'b0)
    else $error("interrupt drive level not low");
  a_flush_zero: assert property ((reg_wr_i && reg_addr_i == 8'h80 && reg_wdata_i[0]) ##2
    (reg_rd_i && reg_addr_i == 8'h82) |=> reg_rdata_o == 16'h0000) else $error("counters kept over flush");
  a_req_off: assert property (w84 && !reg_wdata_i[0] |=> transfer_request_n_o)
    else $error("request after disable");
  a_vec_quiet: assert property (irq_ack_n_i [*4] |-> vector_oe_n_o)
    else $error("vector driven without ack");
  a_irq_drive: assert property (w90 && !reg_wdata_i[7] |-> ##[1:2] !irq_oe_n_o)
    else $error("interrupt not driven");
  a_level_off: assert property ((w84 && reg_wdata_i[4:1] == 4'h0) ##1 (!reg_wr_i) [*2]
    |=> !fifo_level_pin_o) else $error("level pin without enable");
  a_drain_cause: assert property (drain_valid_o |-> $past(drain_i))
    else $error("drain data without pop");
endmodule
bind host_fifo_dma_and_irq_ctrl host_fifo_sva chk (.clk_sys_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_rdata_o, .drain_i, .drain_valid_o, .irq_ack_n_i, .vector_oe_n_o, .irq_n_o, .irq_oe_n_o,
  .fifo_level_pin_o, .transfer_request_n_o);
`default_nettype wire

// ---- tb/host_dma_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_dma_model (
  input wire logic  clk_sys_i,
  input wire logic  rstn_i,
  input wire logic  go_i,
  input wire logic  slow_i,
  input wire logic  transfer_request_n_i,
  output var logic  transfer_ack_o
);
  logic [1:0] gap;
  // Acks only a live request and never twice in a row, so a full FIFO drops the request first.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap <= 2'h0;
      transfer_ack_o <= 1'b0;
    end else begin
      gap <= gap + 2'h1;
      transfer_ack_o <= go_i && !transfer_request_n_i && !transfer_ack_o && (!slow_i || gap == 2'h0);
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_sys_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, drain_i = 1'b0;
  logic        done_n = 1'b1, ack_n = 1'b1, go = 1'b0, ack, req_n, pin, dv, voe_n, ioe_n;
  logic [7:0]  addr = 8'h00, vec;
  logic [15:0] wdata = 16'h0000, rdata, dd;
  logic [15:0] md [3] = '{16'h0000, 16'h4000, 16'hC000};
  int          fail_count = 0, checks_done = 0, cyc = 0, e;
  initial forever #4 clk_sys_i = ~clk_sys_i;
  host_fifo_dma_and_irq_ctrl dut (.clk_sys_i, .rstn_i, .reg_addr_i(addr), .reg_wr_i, .reg_rd_i,
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .transfer_ack_i(ack), .transfer_done_n_i(done_n), .drain_i,
    .drain_data_o(dd), .drain_valid_o(dv), .irq_ack_n_i(ack_n), .host_addr_i(3'h5), .vector_data_o(vec),
    .vector_oe_n_o(voe_n), .irq_n_o(), .irq_oe_n_o(ioe_n), .fifo_level_pin_o(pin), .transfer_request_n_o(req_n));
  host_dma_model partner (.clk_sys_i, .rstn_i, .go_i(go), .slow_i(1'b1), .transfer_request_n_i(req_n),
    .transfer_ack_o(ack));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i) if (++cyc == 3000) begin
    fail_count++;
    give_verdict;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i) reg_wr_i = 1'b0;
    wdata = 16'h0000;
    idle(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    addr = a;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i) reg_rd_i = 1'b0;
    chk(rdata, exp);
    idle(1);
  endtask
  task automatic pop(input logic [15:0] exp);
    drain_i = 1'b1;
    @(negedge clk_sys_i) drain_i = 1'b0;
    chk(dv, 1'b1);
    chk(dd, exp);
    idle(1);
  endtask
  task automatic lvl(input logic [15:0] d, input logic exp);
    wr(8'h84, d);
    idle(2);
    chk(pin, exp);
  endtask
  initial begin
    idle(6);
    rstn_i = 1'b1;
    rd(8'h9C, 16'h000F);
    wr(8'h98, 16'h0525);
    rd(8'h9C, 16'h0525);
    $display("test vector done");
    for (int i = 0; i < 18; i++) begin
      e = (i > 16) ? 0 : 16 - i;
      rd(8'h84, {7'h00, e >= 4, e >= 8, e >= 12, e == 16, 5'h00});
      wr(8'h00, 16'hA500 + 16'(i));
    end
    rd(8'h82, 16'h1000);
    wr(8'h84, 16'h0001);
    rd(8'h84, 16'h0001);
    pop(16'hA500);
    rd(8'h82, 16'h0F01);
    chk(req_n, 1'b1);
    wr(8'h84, 16'h0001);
    chk(req_n, 1'b0);
    go = 1'b1;
    idle(8);
    go = 1'b0;
    rd(8'h82, 16'h1011);
    pop(16'hA501);
    wr(8'h84, 16'h0000);
    chk(req_n, 1'b1);
    wr(8'h84, 16'h0001);
    done_n = 1'b0;
    idle(4);
    done_n = 1'b1;
    rd(8'h84, 16'h0000);
    chk(req_n, 1'b1);
    $display("test dma done");
    wr(8'h80, 16'h0001);
    rd(8'h82, 16'h0000);
    wr(8'h80, 16'h0000);
    lvl(16'h0002, 1'b1);
    wr(8'h00, 16'h1234);
    lvl(16'h0002, 1'b0);
    lvl(16'h0012, 1'b1);
    lvl(16'h0000, 1'b0);
    $display("test level done");
    for (int m = 0; m < 3; m++) begin
      wr(8'h90, md[m]);
      idle(1);
      chk(ioe_n, 1'b0);
      ack_n = 1'b0;
      idle(5);
      chk(voe_n, m == 0);
      if (m > 0) chk(vec, 8'h25);
      ack_n = 1'b1;
      idle(5);
      chk(ioe_n, m == 2);
    end
    rd(8'h90, 16'hC080);
    wr(8'h90, 16'hC080);
    idle(1);
    chk(ioe_n, 1'b1);
    $display("test interrupt done");
    give_verdict;
  end
endmodule
`default_nettype wire
